// ---- include/gp_pkg.sv ----
package gp_pkg;

   localparam int GP_NBIT = 32;
   localparam int GP_NHALF = 8;
   localparam int GP_FSTEPS = 8;

   // -----------------------------------------------------------------
   // Register byte offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] GP_OFS_CMD = 8'h00;
   localparam logic [7:0] GP_OFS_BITSET = 8'h04;
   localparam logic [7:0] GP_OFS_CFG = 8'h08;
   localparam logic [7:0] GP_OFS_MODE = 8'h0c;
   localparam logic [7:0] GP_OFS_TC1 = 8'h10;
   localparam logic [7:0] GP_OFS_TC2 = 8'h14;
   localparam logic [7:0] GP_OFS_TC3 = 8'h18;
   localparam logic [7:0] GP_OFS_TIMER = 8'h1c;
   localparam logic [7:0] GP_OFS_TRAP_RISE = 8'h20;
   localparam logic [7:0] GP_OFS_TRAP_FALL = 8'h24;
   localparam logic [7:0] GP_OFS_VIEW_A = 8'h30;
   localparam logic [7:0] GP_OFS_VIEW_B = 8'h34;
   localparam logic [7:0] GP_OFS_VIEW_C = 8'h38;
   localparam logic [7:0] GP_OFS_VIEW_D = 8'h3c;
   localparam logic [7:0] GP_OFS_OUT_A = 8'h40;
   localparam logic [7:0] GP_OFS_OUT_B = 8'h44;
   localparam logic [7:0] GP_OFS_OUT_C = 8'h48;
   localparam logic [7:0] GP_OFS_OUT_D = 8'h4c;
   localparam logic [7:0] GP_OFS_IRQ_STAT = 8'h50;
   localparam logic [7:0] GP_OFS_IRQ_MASK = 8'h54;

   // -----------------------------------------------------------------
   // Command codes
   // -----------------------------------------------------------------
   localparam logic [7:0] GP_CMD_VIEW_LIVE = 8'he5;
   localparam logic [7:0] GP_CMD_VIEW_LATCH = 8'he7;
   localparam logic [7:0] GP_CMD_VIEW_TRAP = 8'he9;
   localparam logic [7:0] GP_CMD_LATCH = 8'hea;
   localparam logic [7:0] GP_CMD_OUT_SET = 8'heb;
   localparam logic [7:0] GP_CMD_BIT_LIMIT = 8'h20;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int GP_CLK_NS = 100;
   localparam int GP_TC_MIN_NS = 1000;
   localparam int GP_TC_MAX_NS = 32000000;
   localparam int GP_TC_MIN_CYC = (GP_TC_MIN_NS + GP_CLK_NS - 1) / GP_CLK_NS;
   localparam int GP_TC_MAX_CYC = GP_TC_MAX_NS / GP_CLK_NS;
   localparam int GP_TC_MIN_STEP = (GP_TC_MIN_CYC + GP_FSTEPS - 1) / GP_FSTEPS;
   localparam int GP_TC_MAX_STEP = GP_TC_MAX_CYC / GP_FSTEPS;
   localparam logic [15:0] GP_TC_RESET = 16'(GP_TC_MIN_STEP);
   localparam logic [23:0] GP_TIMER_RESET = 24'h00_2710;
   localparam logic [3:0] GP_IRQ_RESET = 4'h0;

   typedef enum logic [1:0] {GP_VIEW_LIVE, GP_VIEW_LATCH, GP_VIEW_TRAP} gp_view_t;

   typedef struct packed {
      logic dir;
      logic pol;
      logic [1:0] fsel;
   } gp_half_cfg_t;

   typedef struct packed {
      logic timer_out;
      logic timer_latch;
      logic out_strobe_fall;
      logic latch_strobe_fall;
      logic sim_out;
   } gp_mode_t;

endpackage

// ---- rtl/gp_top.sv ----
// The register addresses and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
module gp_top
   import gp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq,
   input wire logic bus_mode_select,
   input wire logic latch_strobe,
   input wire logic out_strobe,
   input wire logic [31:0] port_in,
   output logic [31:0] port_out,
   output logic [31:0] port_oe
);

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   logic [34:0] sync1, sync2;
   logic [31:0] pin_s;
   logic mode_s, lstb_s, ostb_s, lstb_d, ostb_d;
   assign pin_s = sync2[31:0];
   assign mode_s = sync2[32];
   assign lstb_s = sync2[33];
   assign ostb_s = sync2[34];
   always_ff @(posedge sys_clk) begin
      // The mode bit leaves reset in bus mode, so no port is driven while the
      // real pin level is still passing the synchroniser. Standalone mode
      // therefore starts a few cycles after reset is released.
      if (srst) begin
         sync1 <= 35'h1_0000_0000;
         sync2 <= 35'h1_0000_0000;
         lstb_d <= 1'b0;
         ostb_d <= 1'b0;
      end else begin
         sync1 <= {out_strobe, latch_strobe, bus_mode_select, port_in};
         sync2 <= sync1;
         lstb_d <= lstb_s;
         ostb_d <= ostb_s;
      end
   end

   // ------------------------------------------------------------------
   // Software state
   // ------------------------------------------------------------------
   gp_half_cfg_t [GP_NHALF-1:0] cfg, next_cfg;
   gp_mode_t mode, next_mode;
   logic [15:0] tc [1:3];
   logic [15:0] next_tc [1:3];
   logic [23:0] tmr_per, next_tmr_per, tmr_cnt, next_tmr_cnt;
   logic [31:0] trap_rise, next_trap_rise, trap_fall, next_trap_fall;
   logic [31:0] out_pend, next_pend, out_live, next_live;
   logic [31:0] latched, next_latched, trap, next_trap;
   logic [3:0] irq_stat, next_stat, irq_mask, next_mask;
   gp_view_t view, next_view;
   logic wait_q, next_wait;
   logic [31:0] rdata, next_rdata;
   logic irq_q, next_irq;
   logic [31:0] pout, next_pout, poe, next_poe;

   logic req, acc_wr, acc_rd;
   logic [31:0] wd;
   logic [31:0] filt, logic_in, logic_d, rise_ev, fall_ev;
   logic [3:0] tick;
   logic tmr_to, lstb_ev, ostb_ev, lat_trig, out_trig;
   logic [7:0] code;

   assign req = avs_read | avs_write;
   assign acc_wr = avs_write & ~wait_q;
   assign acc_rd = avs_read & ~wait_q;
   assign wd = avs_writedata;
   assign code = wd[7:0];
   assign tmr_to = (tmr_per != 24'h0) && (tmr_cnt == 24'h0);
   assign lstb_ev = mode.latch_strobe_fall ? (lstb_d & ~lstb_s) : (~lstb_d & lstb_s);
   assign ostb_ev = mode.out_strobe_fall ? (ostb_d & ~ostb_s) : (~ostb_d & ostb_s);
   assign lat_trig = lstb_ev | (acc_wr && avs_address == GP_OFS_CMD && code == GP_CMD_LATCH)
                     | (tmr_to & mode.timer_latch);
   assign out_trig = ostb_ev | (acc_wr && avs_address == GP_OFS_CMD && code == GP_CMD_OUT_SET)
                     | (tmr_to & mode.timer_out);

   // ------------------------------------------------------------------
   // Filter step ticks, one prescaler per time-constant type
   // ------------------------------------------------------------------
   assign tick[0] = 1'b0;
   genvar t;
   generate
      for (t = 1; t <= 3; t++) begin : g_pre
         logic [15:0] pcnt, next_pcnt;
         always_comb begin
            next_pcnt = (pcnt + 16'h1 >= tc[t]) ? 16'h0 : pcnt + 16'h1;
         end
         assign tick[t] = (pcnt + 16'h1 >= tc[t]);
         always_ff @(posedge sys_clk) begin
            if (srst) begin
               pcnt <= '0;
            end else begin
               pcnt <= next_pcnt;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------------
   // Per-signal integral filter and polarity
   // ------------------------------------------------------------------
   // The counter must sit at full or empty before the level moves, so a
   // glitch shorter than the programmed delay never reaches the logic.
   genvar g;
   generate
      for (g = 0; g < GP_NBIT; g++) begin : g_filt
         logic [2:0] cnt, next_cnt;
         logic lvl, next_lvl;
         logic [1:0] sel;
         always_comb begin
            if (mode_s) begin
               sel = cfg[g/4].fsel;
            end else begin
               sel = (g < 4) ? 2'd1 : (g < 8) ? 2'd2 : 2'd3;
            end
            next_cnt = cnt;
            next_lvl = lvl;
            if (tick[sel]) begin
               if (pin_s[g] && cnt != 3'h7) begin
                  next_cnt = cnt + 3'h1;
               end else if (!pin_s[g] && cnt != 3'h0) begin
                  next_cnt = cnt - 3'h1;
               end
            end
            if (next_cnt == 3'h7) begin
               next_lvl = 1'b1;
            end else if (next_cnt == 3'h0) begin
               next_lvl = 1'b0;
            end
         end
         assign filt[g] = (sel == 2'd0) ? pin_s[g] : lvl;
         assign logic_in[g] = filt[g] ^ (mode_s & cfg[g/4].pol);
         always_ff @(posedge sys_clk) begin
            if (srst) begin
               cnt <= '0;
               lvl <= 1'b0;
            end else begin
               cnt <= next_cnt;
               lvl <= next_lvl;
            end
         end
      end
   endgenerate

   assign rise_ev = logic_in & ~logic_d & trap_rise;
   assign fall_ev = ~logic_in & logic_d & trap_fall;

   // ------------------------------------------------------------------
   // Register file, views, outputs and interrupt
   // ------------------------------------------------------------------
   always_comb begin
      logic [31:0] view_word;
      logic [7:0] view_byte;
      logic [31:0] wmask;
      logic [1:0] pidx;
      view_word = (view == GP_VIEW_LATCH) ? latched : (view == GP_VIEW_TRAP) ? trap : logic_in;
      pidx = avs_address[3:2];
      view_byte = view_word[8*pidx +: 8];
      wmask = 32'hff << (8 * avs_address[3:2]);
      next_cfg = cfg;
      next_mode = mode;
      next_tc = tc;
      next_tmr_per = tmr_per;
      next_tmr_cnt = (tmr_cnt == 24'h0) ? tmr_per : tmr_cnt - 24'h1;
      next_trap_rise = trap_rise;
      next_trap_fall = trap_fall;
      next_pend = out_pend;
      next_mask = irq_mask;
      next_view = view;
      next_latched = lat_trig ? logic_in : latched;
      next_trap = trap;
      next_stat = irq_stat;
      next_wait = !(req && wait_q);
      next_rdata = '0;
      // A read clears only the bits that it returned. An event that lands
      // while the answer is being formed stays set for the next read
      // instead of being lost.
      if (acc_rd && avs_address == GP_OFS_IRQ_STAT) begin
         next_stat = irq_stat & ~rdata[3:0];
      end
      if (acc_rd && view == GP_VIEW_TRAP && avs_address[7:4] == GP_OFS_VIEW_A[7:4]) begin
         next_trap = trap & ~(wmask & {4{rdata[7:0]}});
      end
      next_trap = next_trap | rise_ev | fall_ev;
      next_stat = next_stat | {tmr_to, ostb_ev, lstb_ev, |(rise_ev | fall_ev)};
      if (acc_wr) begin
         unique case (avs_address)
            GP_OFS_CMD: begin
               if (code < GP_CMD_BIT_LIMIT) begin
                  next_pend[code[4:0]] = 1'b0;
               end else if (code == GP_CMD_VIEW_LIVE) begin
                  next_view = GP_VIEW_LIVE;
               end else if (code == GP_CMD_VIEW_LATCH) begin
                  next_view = GP_VIEW_LATCH;
               end else if (code == GP_CMD_VIEW_TRAP) begin
                  next_view = GP_VIEW_TRAP;
               end
            end
            GP_OFS_BITSET: next_pend[wd[4:0]] = 1'b1;
            GP_OFS_CFG: next_cfg = wd;
            GP_OFS_MODE: next_mode = wd[4:0];
            GP_OFS_TC1: next_tc[1] = wd[15:0];
            GP_OFS_TC2: next_tc[2] = wd[15:0];
            GP_OFS_TC3: next_tc[3] = wd[15:0];
            GP_OFS_TIMER: next_tmr_per = wd[23:0];
            GP_OFS_TRAP_RISE: next_trap_rise = wd;
            GP_OFS_TRAP_FALL: next_trap_fall = wd;
            GP_OFS_OUT_A, GP_OFS_OUT_B, GP_OFS_OUT_C, GP_OFS_OUT_D: begin
               next_pend = (out_pend & ~wmask) | ({4{wd[7:0]}} & wmask);
            end
            GP_OFS_IRQ_MASK: next_mask = wd[3:0];
            default: ;
         endcase
      end
      // Held data reaches the live register only on a trigger in
      // simultaneous mode, so ports change in the same cycle.
      next_live = (!mode.sim_out || out_trig) ? next_pend : out_live;
      if (req && wait_q && avs_read) begin
         unique case (avs_address)
            GP_OFS_CFG: next_rdata = cfg;
            GP_OFS_MODE: next_rdata = {27'h0, mode};
            GP_OFS_TC1: next_rdata = {16'h0, tc[1]};
            GP_OFS_TC2: next_rdata = {16'h0, tc[2]};
            GP_OFS_TC3: next_rdata = {16'h0, tc[3]};
            GP_OFS_TIMER: next_rdata = {8'h0, tmr_per};
            GP_OFS_TRAP_RISE: next_rdata = trap_rise;
            GP_OFS_TRAP_FALL: next_rdata = trap_fall;
            GP_OFS_VIEW_A, GP_OFS_VIEW_B, GP_OFS_VIEW_C, GP_OFS_VIEW_D: begin
               next_rdata = {24'h0, view_byte};
            end
            GP_OFS_OUT_A, GP_OFS_OUT_B, GP_OFS_OUT_C, GP_OFS_OUT_D: begin
               next_rdata = {24'h0, out_pend[8*pidx +: 8]};
            end
            GP_OFS_IRQ_STAT: next_rdata = {28'h0, irq_stat};
            GP_OFS_IRQ_MASK: next_rdata = {28'h0, irq_mask};
            default: next_rdata = '0;
         endcase
      end
      next_irq = |(irq_stat & irq_mask);
      if (mode_s) begin
         next_pout = out_live;
         for (int h = 0; h < GP_NHALF; h++) begin
            next_poe[4*h +: 4] = {4{cfg[h].dir}};
         end
      end else begin
         next_pout = {filt[15:0], 16'h0};
         next_poe = 32'hffff_0000;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cfg <= '0;
         mode <= '0;
         tc[1] <= GP_TC_RESET;
         tc[2] <= GP_TC_RESET;
         tc[3] <= GP_TC_RESET;
         tmr_per <= GP_TIMER_RESET;
         tmr_cnt <= GP_TIMER_RESET;
         trap_rise <= '0;
         trap_fall <= '0;
         out_pend <= '0;
         out_live <= '0;
         latched <= '0;
         trap <= '0;
         logic_d <= '0;
         irq_stat <= GP_IRQ_RESET;
         irq_mask <= GP_IRQ_RESET;
         view <= GP_VIEW_LIVE;
         wait_q <= 1'b1;
         rdata <= '0;
         irq_q <= 1'b0;
         pout <= '0;
         poe <= '0;
      end else begin
         cfg <= next_cfg;
         mode <= next_mode;
         tc <= next_tc;
         tmr_per <= next_tmr_per;
         tmr_cnt <= next_tmr_cnt;
         trap_rise <= next_trap_rise;
         trap_fall <= next_trap_fall;
         out_pend <= next_pend;
         out_live <= next_live;
         latched <= next_latched;
         trap <= next_trap;
         logic_d <= logic_in;
         irq_stat <= next_stat;
         irq_mask <= next_mask;
         view <= next_view;
         wait_q <= next_wait;
         rdata <= next_rdata;
         irq_q <= next_irq;
         pout <= next_pout;
         poe <= next_poe;
      end
   end

   assign avs_readdata = rdata;
   assign avs_waitrequest = wait_q;
   assign irq = irq_q;
   assign port_out = pout;
   assign port_oe = poe;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   chk_mode_route: assert property (!mode_s ##1 !mode_s |=> port_oe == 32'hffff_0000)
      else $error("standalone mode does not drive ports C and D only");
   chk_half_drive: assert property (mode_s && cfg[4].dir |=> port_oe[19:16] == 4'hf
      && port_out[19:16] == $past(out_live[19:16]))
      else $error("output half does not drive its live data");
   chk_bypass_raw: assert property (mode_s && cfg[1].fsel == 2'd0 |-> filt[4] == pin_s[4])
      else $error("bypassed input does not follow the pin");
   chk_polarity_apply: assert property (mode_s |-> logic_in[0] == (filt[0] ^ cfg[0].pol))
      else $error("polarity not applied");
   chk_latch_cmd: assert property (acc_wr && avs_address == GP_OFS_CMD
      && code == GP_CMD_LATCH |=> latched == $past(logic_in))
      else $error("latch command did not capture inputs");
   chk_view_select: assert property (acc_wr && avs_address == GP_OFS_CMD
      && code == GP_CMD_VIEW_TRAP |=> view == GP_VIEW_TRAP)
      else $error("view select command ignored");
   chk_trap_clear: assert property (acc_rd && view == GP_VIEW_TRAP
      && avs_address == GP_OFS_VIEW_A && (rise_ev[7:0] | fall_ev[7:0]) == 8'h0
      |=> (trap[7:0] & $past(avs_readdata[7:0])) == 8'h0)
      else $error("trap read did not clear port A");
   chk_bit_clear: assert property (acc_wr && avs_address == GP_OFS_CMD && code < 8'h20
      |=> out_pend == ($past(out_pend) & ~(32'h1 << $past(code[4:0]))))
      else $error("bit clear touched other bits");
   chk_port_write: assert property (acc_wr && avs_address == GP_OFS_OUT_C && !mode.sim_out
      |=> out_live[23:16] == $past(wd[7:0]))
      else $error("port write did not reach live data");
   chk_sim_hold: assert property (mode.sim_out && !out_trig |=> $stable(out_live))
      else $error("held output data changed without trigger");
   chk_sim_fire: assert property (mode.sim_out && out_trig |=> out_live == out_pend)
      else $error("trigger did not drive pending data");
   chk_bus_answer: assert property (req && wait_q |=> !avs_waitrequest)
      else $error("slave did not answer in one cycle");
   chk_read_idle: assert property (avs_waitrequest |-> avs_readdata == 32'h0)
      else $error("read data shown outside the answer cycle");
   chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   chk_irq_level: assert property (|(irq_stat & irq_mask) |=> irq)
      else $error("unmasked status did not raise the interrupt");
   chk_stat_clear: assert property (acc_rd && avs_address == GP_OFS_IRQ_STAT && !tmr_to
      && !lstb_ev && !ostb_ev && (rise_ev | fall_ev) == 32'h0
      |=> (irq_stat & $past(avs_readdata[3:0])) == 4'h0)
      else $error("status read did not clear the reported bits");
   chk_trap_set: assert property (rise_ev[0] || fall_ev[0] |=> trap[0])
      else $error("transition on the first input was not trapped");
   chk_strobe_latch: assert property (lstb_ev |=> latched == $past(logic_in))
      else $error("latch strobe did not capture inputs");
   chk_bit_set: assert property (acc_wr && avs_address == GP_OFS_BITSET
      |=> out_pend[$past(wd[4:0])])
      else $error("bit set did not reach pending data");
   chk_view_live: assert property (acc_wr && avs_address == GP_OFS_CMD
      && code == GP_CMD_VIEW_LIVE |=> view == GP_VIEW_LIVE)
      else $error("live view command ignored");
   chk_standalone_out: assert property (!mode_s |=> port_out == {$past(filt[15:0]), 16'h0})
      else $error("standalone outputs do not show filtered inputs");

endmodule // gp_top

// ---- bench/gp_host_model.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------------
// Host processor model on the Avalon-MM register bus
// ---------------------------------------------------------------------
module gp_host_model
   import gp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic avs_waitrequest,
   input wire logic [31:0] avs_readdata,
   output logic [7:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata
);
   initial begin
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
   end

   // Requests rise just after an edge and are held until waitrequest is seen low.
   // Commands for view select, latch and bit control all go through this task.
   task automatic bus_write(input logic [7:0] addr, input logic [31:0] data);
      @(posedge sys_clk);
      avs_address <= addr;
      avs_writedata <= data;
      avs_write <= 1'b1;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
   endtask

   task automatic bus_read(input logic [7:0] addr, output logic [31:0] data);
      @(posedge sys_clk);
      avs_address <= addr;
      avs_read <= 1'b1;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      data = avs_readdata;
      avs_read <= 1'b0;
   endtask
endmodule // gp_host_model

// ---- bench/tb_gp_top.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------------
// Self-checking bench for the filtered GPIO block
// ---------------------------------------------------------------------
module tb_gp_top;
   import gp_pkg::*;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic bus_mode_select = 1'b1;
   logic latch_strobe = 1'b0;
   logic out_strobe = 1'b0;
   logic [31:0] port_in = 32'h0000_0000;
   logic [7:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic irq;
   logic [31:0] port_out;
   logic [31:0] port_oe;
   logic [31:0] rd;
   int miscompares = 0;
   int total_checks = 0;

   always #50 sys_clk = ~sys_clk;

   gp_top gp_top_i (.sys_clk(sys_clk), .srst(srst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
      .bus_mode_select(bus_mode_select), .latch_strobe(latch_strobe),
      .out_strobe(out_strobe), .port_in(port_in), .port_out(port_out), .port_oe(port_oe));

   gp_host_model gp_host_model_i (.sys_clk(sys_clk), .avs_waitrequest(avs_waitrequest),
      .avs_readdata(avs_readdata), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata));

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] addr, input logic [31:0] data);
      gp_host_model_i.bus_write(addr, data);
   endtask

   task automatic rdchk(input string what, input logic [7:0] addr, input logic [31:0] exp);
      gp_host_model_i.bus_read(addr, rd);
      check(what, rd, exp);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic print_verdict;
      if (miscompares == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // The whole sequence takes well under a thousand cycles.
   initial begin
      #(100 * 20000);
      miscompares++;
      print_verdict();
   end

   // ------------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------------
   initial begin
      cyc(16);
      srst <= 1'b0;
      check("oe_after_reset", port_oe, 32'h0000_0000);
      check("wait_after_reset", {31'h0, avs_waitrequest}, 32'h0000_0001);
      cyc(2);
      check("oe_after_release", port_oe, 32'h0000_0000);
      // Ports C and D drive, A and B read; upper half of A reads inverted.
      wr(GP_OFS_CFG, 32'h8888_0040);
      cyc(3);
      check("port_oe", port_oe, 32'hffff_0000);
      port_in <= 32'h0000_c33c;
      wr(GP_OFS_CMD, {24'h0, GP_CMD_VIEW_LIVE});
      cyc(4);
      rdchk("live_view_a", GP_OFS_VIEW_A, 32'h0000_00cc);
      rdchk("live_view_b", GP_OFS_VIEW_B, 32'h0000_00c3);
      rdchk("unmapped", 8'h2c, 32'h0000_0000);

      // Command latch, then the pins move on; the latched view keeps the old value.
      wr(GP_OFS_CMD, {24'h0, GP_CMD_LATCH});
      port_in <= 32'h0000_c300;
      wr(GP_OFS_CMD, {24'h0, GP_CMD_VIEW_LATCH});
      cyc(4);
      rdchk("latched_cmd", GP_OFS_VIEW_A, 32'h0000_00cc);
      // Strobe latch with its interrupt masked, then unmasked, then cleared by a read.
      wr(GP_OFS_IRQ_MASK, 32'h0000_0000);
      latch_strobe <= 1'b1;
      cyc(6);
      rdchk("latched_strobe", GP_OFS_VIEW_A, 32'h0000_00f0);
      check("irq_masked", {31'h0, irq}, 32'h0000_0000);
      wr(GP_OFS_IRQ_MASK, 32'h0000_0002);
      cyc(3);
      check("irq_unmasked", {31'h0, irq}, 32'h0000_0001);
      gp_host_model_i.bus_read(GP_OFS_IRQ_STAT, rd);
      check("irq_stat_strobe", {31'h0, rd[1]}, 32'h0000_0001);
      latch_strobe <= 1'b0;
      cyc(3);
      check("irq_cleared", {31'h0, irq}, 32'h0000_0000);

      // Rising transition on A0 is trapped once and cleared by the read.
      wr(GP_OFS_TRAP_RISE, 32'h0000_0001);
      wr(GP_OFS_CMD, {24'h0, GP_CMD_VIEW_TRAP});
      gp_host_model_i.bus_read(GP_OFS_VIEW_A, rd);
      port_in <= 32'h0000_c301;
      cyc(5);
      rdchk("trap_set", GP_OFS_VIEW_A, 32'h0000_0001);
      rdchk("trap_cleared", GP_OFS_VIEW_A, 32'h0000_0000);

      // Whole-port writes, then single-bit set and clear.
      wr(GP_OFS_OUT_C, 32'h0000_005a);
      wr(GP_OFS_OUT_D, 32'h0000_00a5);
      cyc(3);
      check("port_write", port_out[31:16], 32'h0000_a55a);
      wr(GP_OFS_BITSET, 32'h0000_0010);
      wr(GP_OFS_CMD, 32'h0000_0011);
      cyc(3);
      check("bit_control", port_out[31:16], 32'h0000_a559);

      // Simultaneous output: data is held until the command or the strobe.
      wr(GP_OFS_MODE, 32'h0000_0001);
      wr(GP_OFS_OUT_C, 32'h0000_0011);
      wr(GP_OFS_OUT_D, 32'h0000_0022);
      cyc(3);
      check("sim_held", port_out[31:16], 32'h0000_a559);
      wr(GP_OFS_CMD, {24'h0, GP_CMD_OUT_SET});
      cyc(3);
      check("sim_cmd_fire", port_out[31:16], 32'h0000_2211);
      wr(GP_OFS_OUT_C, 32'h0000_0033);
      cyc(3);
      check("sim_held_again", port_out[31:16], 32'h0000_2211);
      out_strobe <= 1'b1;
      cyc(6);
      check("sim_strobe_fire", port_out[31:16], 32'h0000_2233);
      out_strobe <= 1'b0;

      // Type-1 filter on A[3:0]: seven steps of two cycles delay the change.
      wr(GP_OFS_TC1, 32'h0000_0002);
      wr(GP_OFS_CFG, 32'h8888_0041);
      wr(GP_OFS_CMD, {24'h0, GP_CMD_VIEW_LIVE});
      cyc(40);
      port_in <= 32'h0000_c303;
      cyc(4);
      rdchk("filter_early", GP_OFS_VIEW_A, 32'h0000_00f1);
      cyc(40);
      rdchk("filter_late", GP_OFS_VIEW_A, 32'h0000_00f3);

      // Standalone mode: C and D show filtered A and B with no polarity.
      bus_mode_select <= 1'b0;
      port_in <= 32'h0000_5a0f;
      cyc(100);
      check("standalone_oe", port_oe, 32'hffff_0000);
      check("standalone_out", port_out[31:16], 32'h0000_5a0f);
      print_verdict();
   end
endmodule // tb_gp_top
